// ### src/ccp_pkg.sv
// Package: register map, field layout, mode codes and timing constants
package ccp_pkg;
   // Register byte offsets (APB, one aligned word each)
   localparam logic [11:0] OFF_MODE_CONTROL = 12'h000;
   localparam logic [11:0] OFF_DUTY_HIGH    = 12'h004;
   localparam logic [11:0] OFF_COMPARE      = 12'h008;
   localparam logic [11:0] OFF_CAPTURE      = 12'h00c;
   localparam logic [11:0] OFF_PERIOD_LIMIT = 12'h010;
   localparam logic [11:0] OFF_STATUS       = 12'h014;
   localparam logic [11:0] OFF_MASK         = 12'h018;
   localparam logic [11:0] OFF_TIMER        = 12'h01c;
   // Mode control field layout
   localparam int MODE_LSB    = 0;
   localparam int MODE_MSB    = 3;
   localparam int DUTY_LO_LSB = 4;
   localparam int DUTY_LO_MSB = 5;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Mode codes
   localparam logic [3:0] M_OFF      = 4'h0;
   localparam logic [3:0] M_TOGGLE   = 4'h2;
   localparam logic [3:0] M_CAP_FALL = 4'h4;
   localparam logic [3:0] M_CAP_RISE = 4'h5;
   localparam logic [3:0] M_CAP_4    = 4'h6;
   localparam logic [3:0] M_CAP_16   = 4'h7;
   localparam logic [3:0] M_CMP_SET  = 4'h8;
   localparam logic [3:0] M_CMP_CLR  = 4'h9;
   localparam logic [3:0] M_CMP_SW   = 4'ha;
   localparam logic [3:0] M_CMP_ADC  = 4'hb;
   // Prescale end counts for capture every 4th and 16th edge
   localparam logic [3:0] PRE_4_END  = 4'h3;
   localparam logic [3:0] PRE_16_END = 4'hf;
   // Status bits
   localparam int ST_EVENT = 0;
   localparam int ST_CAP   = 1;
   localparam int ST_W     = 2;
   // Time base: 2-bit sub-count below the 8-bit period timer
   localparam logic [1:0] SUB_LAST = 2'h3;
   typedef enum logic [1:0] {
      CLS_OFF,
      CLS_CAPTURE,
      CLS_COMPARE,
      CLS_PWM
   } mode_class_e;
endpackage

// ### src/ccp_if.sv
// Interface: time base signals shared between the top and the timer
`timescale 1ns/1ps
interface ccp_tb_if;
   logic        run;       // Time base counts
   logic [7:0]  limit;     // Period limit
   logic [7:0]  timer;     // Period timer value
   logic [1:0]  sub;       // Low two bits of the 10-bit base
   logic        wrap;      // Pulse: period complete, timer cleared
   modport timer_side (input run, input limit,
                       output timer, output sub, output wrap);
   modport user_side  (output run, output limit,
                       input timer, input sub, input wrap);
endinterface

// ### src/ccp_timebase.sv
// Period timer with 2-bit sub-count forming a 10-bit time base
`timescale 1ns/1ps
module ccp_timebase
   import ccp_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_sys_i,
   input  wire logic     resetn_i,
   input  wire logic     ce_i,
   // Time base link
   ccp_tb_if.timer_side  tb
);
   logic [7:0] next_timer;   // Next timer value
   logic [1:0] next_sub;     // Next sub-count
   logic       next_wrap;    // Next wrap pulse

   // Count sub then timer; clear on the increment after the limit
   always_comb begin
      next_timer = tb.timer;
      next_sub   = tb.sub;
      next_wrap  = 1'b0;
      if (!tb.run) begin
         // Held cleared while stopped
         next_timer = 8'h00;
         next_sub   = 2'h0;
      end else if (tb.sub != SUB_LAST) begin
         next_sub = tb.sub + 2'h1;
      end else begin
         next_sub = 2'h0;
         if (tb.timer == tb.limit) begin
            next_timer = 8'h00;  // [R13]
            next_wrap  = 1'b1;
         end else begin
            next_timer = tb.timer + 8'h01;
         end
      end
   end

   // Register the time base
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tb.timer <= 8'h00;
         tb.sub   <= 2'h0;
         tb.wrap  <= 1'b0;
      end else if (ce_i) begin
         tb.timer <= next_timer;
         tb.sub   <= next_sub;
         tb.wrap  <= next_wrap;
      end
   end
endmodule

// ### src/ccp_capture.sv
// Capture edge detector with selectable edge and prescale
`timescale 1ns/1ps
module ccp_capture
   import ccp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       ce_i,
   // Control
   input  wire logic [3:0] mode_i,
   input  wire logic       cap_in_i,
   // Result
   output logic            cap_o
);
   logic       prev;          // Previous input level
   logic [3:0] pre;           // Rising edge prescaler
   logic       next_prev;
   logic [3:0] next_pre;
   logic       next_cap;

   // Edge select and prescaler; any non-capture mode clears it
   always_comb begin
      next_prev = cap_in_i;
      next_pre  = pre;
      next_cap  = 1'b0;
      unique case (mode_i)
         M_CAP_FALL: next_cap = prev & ~cap_in_i;   // [R7]
         M_CAP_RISE: next_cap = ~prev & cap_in_i;   // [R7]
         M_CAP_4: begin
            if (~prev & cap_in_i) begin
               next_cap = (pre[1:0] == PRE_4_END[1:0]);  // [R6]
               next_pre = next_cap ? 4'h0 : pre + 4'h1;
            end
         end
         M_CAP_16: begin
            if (~prev & cap_in_i) begin
               next_cap = (pre == PRE_16_END);      // [R5]
               next_pre = next_cap ? 4'h0 : pre + 4'h1;
            end
         end
         default: next_pre = 4'h0;  // Other modes do not capture
      endcase
   end

   // Register edge state
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev  <= 1'b0;
         pre   <= 4'h0;
         cap_o <= 1'b0;
      end else if (ce_i) begin
         prev  <= next_prev;
         pre   <= next_pre;
         cap_o <= next_cap;
      end
   end
endmodule

// ### src/ccp_unit.sv
// Capture/compare/PWM unit with APB registers and interrupt
// Functional notes
// [R1] PWM duty low two bits from control
// [R2] Code 1011: flag and ADC trigger
// [R3] Code 1010: flag only, pin unchanged
// [R4] Compare set, clear, toggle output pin
// [R5] Code 0111: capture every sixteenth rising edge
// [R6] Code 0110: capture every fourth rising edge
// [R7] Codes 0101/0100: rising or falling capture
// [R8] Code 0000: unit off, held reset
// [R9] Control bits 7:6 read zero
// [R10] Control register clears on reset
// [R11] Mode bits 3:2 ones select PWM
// [R12] Software avoids reserved codes 0011, 0001
// [R13] Period end clears timer, sets pin; the code leaves the pin low when duty is zero
// [R14] Pin low when base equals duty
`timescale 1ns/1ps
module ccp_unit
   import ccp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Capture input and unit pin
   input  wire logic        cap_in_i,
   output logic             pin_o,
   // ADC side
   input  wire logic        adc_enable_i,
   output logic             adc_start_o,
   // Interrupt
   output logic             irq_o
);
   // Registers
   logic [7:0]      unit_mode_control;  // Mode and duty low bits
   logic [7:0]      duty_high_byte;     // Duty upper byte
   logic [15:0]     compare_value;      // Compare target
   logic [15:0]     capture_value;      // Last captured time
   logic [7:0]      period_limit;       // PWM period limit
   logic [ST_W-1:0] status;             // Sticky events
   logic [ST_W-1:0] mask;               // Interrupt mask
   // PWM shadow state
   logic [7:0]      duty_shadow;        // Latched duty high part
   logic [1:0]      duty_low_latch;     // Latched duty low part
   logic            pin;                // Output pin state
   logic            match_d;            // Compare match seen last cycle
   // Next values
   logic [7:0]      next_ctrl;
   logic [7:0]      next_dhb;
   logic [15:0]     next_cmp;
   logic [15:0]     next_capv;
   logic [7:0]      next_lim;
   logic [ST_W-1:0] next_status;
   logic [ST_W-1:0] next_mask;
   logic [7:0]      next_dshadow;
   logic [1:0]      next_dlow;
   logic            next_pin;
   logic            next_match_d;
   logic            next_adc;
   logic            next_irq;
   logic [31:0]     next_rdata;
   logic            next_ready;
   logic            next_err;
   // Decode
   logic [3:0]      unit_mode_select;
   logic [1:0]      duty_low_bits;
   mode_class_e     cls;
   logic            acc;
   logic            wr;
   logic            mapped;
   logic            cap_hit;
   logic            match;
   logic            cmp_event;
   logic [9:0]      base;
   logic [9:0]      duty10;
   logic [ST_W-1:0] ev;
   ccp_tb_if        tb ();

   // Field views of the control register; bits 7:6 are never stored
   assign unit_mode_select = unit_mode_control[MODE_MSB:MODE_LSB];
   assign duty_low_bits    = unit_mode_control[DUTY_LO_MSB:DUTY_LO_LSB];

   // Mode class decode; PWM on bits 3:2 both set
   // Reserved codes fall through to off so the unit stays quiet
   always_comb begin
      if (unit_mode_select[3:2] == 2'b11) begin
         cls = CLS_PWM;                                   // [R11]
      end else if (unit_mode_select[3] ||
                   unit_mode_select == M_TOGGLE) begin
         cls = CLS_COMPARE;
      end else if (unit_mode_select[2]) begin
         cls = CLS_CAPTURE;
      end else begin
         cls = CLS_OFF;  // Off and reserved codes do nothing [R8] [R12]
      end
   end

   // Time base runs in PWM and compare, stopped otherwise
   assign tb.run   = (cls == CLS_PWM) || (cls == CLS_COMPARE);
   assign tb.limit = period_limit;
   assign base     = {tb.timer, tb.sub};
   assign duty10   = {duty_shadow, duty_low_latch};

   // Shared period timer; held cleared whenever run is low
   ccp_timebase u_timebase (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .tb        (tb)
   );

   // Edge detector; its prescaler clears outside the capture modes and holds in rise/fall
   ccp_capture u_capture (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .mode_i    (unit_mode_select),
      .cap_in_i  (cap_in_i),
      .cap_o     (cap_hit)
   );

   // Compare match is taken once, on its first cycle only
   assign match     = (cls == CLS_COMPARE) &&
                      ({6'h00, base} == compare_value);
   assign cmp_event = match && !match_d;

   // APB access phase: pready follows one cycle later (one wait state).
   // A write lands only at the edge at which the master sees pready, so
   // a register never changes before the transfer has completed.
   assign acc = psel_i && penable_i && !pready_o;
   assign wr  = psel_i && penable_i && pready_o && pwrite_i;
   always_comb begin
      unique case (paddr_i)
         OFF_MODE_CONTROL, OFF_DUTY_HIGH, OFF_COMPARE, OFF_CAPTURE,
         OFF_PERIOD_LIMIT, OFF_STATUS, OFF_MASK, OFF_TIMER: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Register file next values and read mux
   always_comb begin
      next_ctrl  = unit_mode_control;
      next_dhb   = duty_high_byte;
      next_cmp   = compare_value;
      next_lim   = period_limit;
      next_mask  = mask;
      next_rdata = prdata_o;
      next_ready = acc;
      next_err   = acc && !mapped;
      if (wr) begin
         unique case (paddr_i)
            OFF_MODE_CONTROL: next_ctrl = pwdata_i[7:0] & CTRL_WMASK; // [R9]
            OFF_DUTY_HIGH:    next_dhb  = pwdata_i[7:0];
            OFF_COMPARE:      next_cmp  = pwdata_i[15:0];
            OFF_PERIOD_LIMIT: next_lim  = pwdata_i[7:0];
            OFF_MASK:         next_mask = pwdata_i[ST_W-1:0];
            default: ;
         endcase
      end
      // Read data is captured at the access edge and stands with pready;
      // upper bits of narrow registers read as zero
      if (acc && !pwrite_i) begin
         unique case (paddr_i)
            OFF_MODE_CONTROL: next_rdata = {24'h0, unit_mode_control}; // [R9]
            OFF_DUTY_HIGH:    next_rdata = {24'h0, duty_high_byte};
            OFF_COMPARE:      next_rdata = {16'h0, compare_value};
            OFF_CAPTURE:      next_rdata = {16'h0, capture_value};
            OFF_PERIOD_LIMIT: next_rdata = {24'h0, period_limit};
            OFF_STATUS:       next_rdata = {30'h0, status};
            OFF_MASK:         next_rdata = {30'h0, mask};
            OFF_TIMER:        next_rdata = {22'h0, base};
            default:          next_rdata = 32'h0;
         endcase
      end
   end

   // Unit behaviour: capture, compare, PWM, events
   always_comb begin
      next_capv    = capture_value;
      next_dshadow = duty_shadow;
      next_dlow    = duty_low_latch;
      next_pin     = pin;
      next_match_d = match;
      next_adc     = 1'b0;
      ev           = '0;
      unique case (cls)
         CLS_OFF: begin
            // Pin and compare match history held cleared; time base stopped
            next_pin     = 1'b0;                          // [R8]
            next_match_d = 1'b0;
         end
         CLS_CAPTURE: begin
            // The time base is stopped in capture modes, so the stamp
            // holds the cleared base; a free-running timer is left out
            if (cap_hit) begin
               next_capv    = {6'h00, base};
               ev[ST_CAP]   = 1'b1;
            end
         end
         CLS_COMPARE: begin
            if (cmp_event) begin
               if (unit_mode_select == M_CMP_SET) begin
                  next_pin      = 1'b1;                   // [R4]
                  ev[ST_EVENT]  = 1'b1;                   // [R4]
               end else if (unit_mode_select == M_CMP_CLR) begin
                  next_pin      = 1'b0;                   // [R4]
                  ev[ST_EVENT]  = 1'b1;                   // [R4]
               end else if (unit_mode_select == M_TOGGLE) begin
                  next_pin      = ~pin;                   // [R4]
               end else if (unit_mode_select == M_CMP_SW) begin
                  ev[ST_EVENT]  = 1'b1;                   // [R3]
               end else if (unit_mode_select == M_CMP_ADC) begin
                  ev[ST_EVENT]  = 1'b1;                   // [R2]
                  next_adc      = adc_enable_i;           // [R2]
               end
            end
         end
         CLS_PWM: begin
            // Duty is double buffered: software writes reach the pin only
            // at the next period start, which keeps each period glitch free
            if (tb.wrap) begin
               // Period restart: latch duty, set pin unless duty zero
               next_dshadow = duty_high_byte;             // [R13]
               next_dlow    = duty_low_bits;              // [R1]
               next_pin     = ({duty_high_byte, duty_low_bits} != 10'h0);
            end else if (base == duty10) begin
               next_pin     = 1'b0;                       // [R14]
            end
         end
      endcase
      // Hardware set wins over a software clear in the same cycle
      next_status = status;
      if (wr && paddr_i == OFF_STATUS) begin
         next_status = status & ~pwdata_i[ST_W-1:0];
      end
      next_status = next_status | ev;
      next_irq    = |(next_status & next_mask);
   end

   // Register all state; every writable bit clears on reset
   // Clock enable low holds every flop, the bus answer included
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         unit_mode_control <= CTRL_RESET;                 // [R10]
         duty_high_byte    <= 8'h00;
         compare_value     <= 16'h0000;
         capture_value     <= 16'h0000;
         period_limit      <= 8'h00;
         status            <= '0;
         mask              <= '0;
         duty_shadow       <= 8'h00;
         duty_low_latch    <= 2'h0;
         pin               <= 1'b0;
         match_d           <= 1'b0;
         adc_start_o       <= 1'b0;
         irq_o             <= 1'b0;
         prdata_o          <= 32'h0;
         pready_o          <= 1'b0;
         pslverr_o         <= 1'b0;
      end else if (ce_i) begin
         unit_mode_control <= next_ctrl;
         duty_high_byte    <= next_dhb;
         compare_value     <= next_cmp;
         capture_value     <= next_capv;
         period_limit      <= next_lim;
         status            <= next_status;
         mask              <= next_mask;
         duty_shadow       <= next_dshadow;
         duty_low_latch    <= next_dlow;
         pin               <= next_pin;
         match_d           <= next_match_d;
         adc_start_o       <= next_adc;
         irq_o             <= next_irq;
         prdata_o          <= next_rdata;
         pready_o          <= next_ready;
         pslverr_o         <= next_err;
      end
   end

   // Pin leaves straight from its flop, with no gate after it
   assign pin_o = pin;
endmodule

// ### tb/ccp_unit_chk.sv
// Checker: bus handshake and mode-driven outputs of the unit
`timescale 1ns/1ps
module ccp_unit_chk
   import ccp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // Bus
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [31:0] prdata_o,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   // Pins
   input  wire logic        cap_in_i,
   input  wire logic        pin_o,
   input  wire logic        adc_enable_i,
   input  wire logic        adc_start_o,
   input  wire logic        irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic [5:0] ctrl;       // Shadow of writable control bits
   logic [5:0] next_ctrl;  // Next shadow value
   logic [3:0] mode;       // Mode field of the shadow
   logic       take;       // Access cycle before the answer
   logic       land;       // Completing edge at which a write lands
   assign take = psel_i && penable_i && !pready_o && ce_i;
   assign land = psel_i && penable_i && pready_o && ce_i;
   assign mode = ctrl[3:0];
   // Shadow follows control writes at the completing edge only
   always_comb begin
      next_ctrl = ctrl;
      if (land && pwrite_i && paddr_i == OFF_MODE_CONTROL) begin
         next_ctrl = pwdata_i[5:0];
      end
   end
   // Cleared by reset like the real register
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= 6'h00;
      end else begin
         ctrl <= next_ctrl;
      end
   end
   property p_ready_pulse; pready_o && ce_i |=> !pready_o; endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held over one cycle");
   property p_answer; take |=> pready_o; endproperty
   a_answer: assert property (p_answer)
      else $error("no answer one cycle after take");
   property p_err; pslverr_o |-> pready_o; endproperty
   a_err: assert property (p_err)
      else $error("error without ready");
   // Readback must match what software wrote, top bits zero
   property p_ctrl_read;
      pready_o && !pwrite_i && paddr_i == OFF_MODE_CONTROL
         |-> prdata_o == {26'h0, ctrl};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control readback wrong");
   property p_off_pin; mode == M_OFF ##1 mode == M_OFF |-> !pin_o;
   endproperty
   a_off_pin: assert property (p_off_pin)
      else $error("pin high while unit off");
   property p_sw_pin; mode == M_CMP_SW [*3] |-> $stable(pin_o);
   endproperty
   a_sw_pin: assert property (p_sw_pin)
      else $error("pin moved in flag-only mode");
   property p_adc_pulse; adc_start_o && ce_i |=> !adc_start_o;
   endproperty
   a_adc_pulse: assert property (p_adc_pulse)
      else $error("trigger longer than one cycle");
   // Trigger only from the trigger mode with the converter enabled
   property p_adc_cause;
      adc_start_o |-> $past(adc_enable_i) && $past(mode) == M_CMP_ADC;
   endproperty
   a_adc_cause: assert property (p_adc_cause)
      else $error("trigger without cause");
   property p_rst_quiet;
      !$past(resetn_i) |-> !pin_o && !irq_o && !adc_start_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("output active right after reset");
endmodule
bind ccp_unit ccp_unit_chk chk (.clk_sys_i, .resetn_i, .ce_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
   .pslverr_o, .cap_in_i, .pin_o, .adc_enable_i, .adc_start_o, .irq_o);

// ### tb/ccp_far_model.sv
// Far-side model: capture input source and output pin observer
`timescale 1ns/1ps
module ccp_far_model (
   // Clock
   input  wire logic clk_sys_i,
   // Pins
   input  wire logic pin_i,
   output logic      cap_o
);
   int   toggles = 0;      // Pin level changes seen
   int   high_cycles = 0;  // Cycles with the pin high
   logic last;             // Pin level one edge ago
   initial cap_o = 1'b0;
   // Counters move by non-blocking update so readers never race
   always @(posedge clk_sys_i) begin
      last <= pin_i;
      if (pin_i !== last) toggles <= toggles + 1;
      if (pin_i === 1'b1) high_cycles <= high_cycles + 1;
   end
   // Each level is held four cycles, beyond the edge detector delay
   task automatic rise();
      @(posedge clk_sys_i);
      cap_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
   endtask
   task automatic fall();
      @(posedge clk_sys_i);
      cap_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask
endmodule

// ### tb/capture_compare_pwm_mode_control_test.sv
// Testbench: register, capture, interrupt, compare and PWM tests
`timescale 1ns/1ps
module capture_compare_pwm_mode_control_test
   import ccp_pkg::*;
;
   logic        clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic        pready_o, pslverr_o, cap_in_i, pin_o, err;
   logic        adc_enable_i, adc_start_o, irq_o, ce_i;
   int          bad_count = 0, checks_done = 0, adc_seen = 0, t0, a0;
   // Capture modes and edges of the selected kind needed per capture
   logic [3:0] cm [4] = '{M_CAP_RISE, M_CAP_FALL, M_CAP_4, M_CAP_16};
   int         ce [4] = '{1, 1, 4, 16};
   // Compare rows; -1 skips; reserved codes never written
   logic [3:0] km [6] = '{M_CMP_SET, M_CMP_CLR, M_TOGGLE, M_CMP_SW,
                          M_CMP_ADC, M_CMP_ADC};
   int kpin [6] = '{1, 0, -1, -1, -1, -1};
   int ktog [6] = '{-1, -1, 2, 0, -1, -1};
   int kflg [6] = '{1, 1, 0, 1, 1, 1};
   int kadc [6] = '{0, 0, 0, 0, 0, 2};
   // PWM rows: control, duty high byte, high cycles in two periods
   logic [7:0] pc [4] = '{8'h2c, 8'h1c, 8'h2f, 8'h0c};
   logic [7:0] pd [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
   int         ph [4] = '{12, 10, 12, 0};
   ccp_unit uut (.clk_sys_i, .resetn_i, .ce_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .cap_in_i, .pin_o, .adc_enable_i, .adc_start_o, .irq_o);
   ccp_far_model far (.clk_sys_i, .pin_i(pin_o), .cap_o(cap_in_i));
   always #10 clk_sys_i = ~clk_sys_i;
   // Count trigger pulses without racing the readers
   always @(posedge clk_sys_i) begin
      if (adc_start_o === 1'b1) adc_seen <= adc_seen + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   // One bus transfer; waits for ready with no cycle count assumed
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      rd  = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      check(rd, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      tick(20000);
      bad_count++;
      summarize();
   end
   initial begin
      clk_sys_i = 1'b0;
      resetn_i = 1'b0;
      {psel_i, penable_i, pwrite_i, adc_enable_i} = 4'h0;
      ce_i = 1'b1;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      tick(10);
      resetn_i <= 1'b1;
      rdc(OFF_MODE_CONTROL, 32'h0);
      wr(OFF_MODE_CONTROL, 32'hff);
      rdc(OFF_MODE_CONTROL, 32'h3f);
      apb(12'h020, 1'b0, 32'h0);
      check(rd, 32'h0);
      check(err, 32'h1);
      resetn_i <= 1'b0;
      tick(3);
      resetn_i <= 1'b1;
      rdc(OFF_MODE_CONTROL, 32'h0);
      $display("registers done");
      wr(OFF_MASK, 32'h3);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_MODE_CONTROL, 32'h0);
         wr(OFF_MODE_CONTROL, {28'h0, cm[i]});
         wr(OFF_STATUS, 32'h3);
         repeat (ce[i] - 1) begin
            far.rise();
            far.fall();
         end
         rdc(OFF_STATUS, 32'h0);
         far.rise();
         rdc(OFF_STATUS, {30'h0, cm[i] != M_CAP_FALL, 1'b0});
         far.fall();
         rdc(OFF_STATUS, 32'h2);
      end
      $display("capture done");
      check(irq_o, 32'h1);
      wr(OFF_MASK, 32'h0);
      tick(2);
      check(irq_o, 32'h0);
      wr(OFF_MASK, 32'h3);
      tick(2);
      check(irq_o, 32'h1);
      wr(OFF_STATUS, 32'h2);
      tick(2);
      check(irq_o, 32'h0);
      $display("interrupt done");
      wr(OFF_PERIOD_LIMIT, 32'h3);
      wr(OFF_COMPARE, 32'h5);
      for (int i = 0; i < 6; i++) begin
         adc_enable_i <= (i == 5);
         wr(OFF_MODE_CONTROL, {28'h0, km[i]});
         wr(OFF_STATUS, 32'h3);
         t0 = far.toggles;
         a0 = adc_seen;
         tick(32);
         rdc(OFF_STATUS, 32'(kflg[i]));
         if (kpin[i] >= 0) check(pin_o, 32'(kpin[i]));
         if (ktog[i] >= 0) check(far.toggles - t0, ktog[i]);
         check(adc_seen - a0, kadc[i]);
      end
      $display("compare done");
      for (int i = 0; i < 4; i++) begin
         wr(OFF_DUTY_HIGH, {24'h0, pd[i]});
         wr(OFF_MODE_CONTROL, {24'h0, pc[i]});
         tick(20);
         t0 = far.high_cycles;
         tick(32);
         check(far.high_cycles - t0, ph[i]);
      end
      // Enable low must freeze a running PWM; duty 2 gives 4 edges in 32
      wr(OFF_MODE_CONTROL, 32'h2c);
      tick(20);
      ce_i <= 1'b0;
      tick(2);
      t0 = far.toggles;
      tick(40);
      check(far.toggles - t0, 0);
      ce_i <= 1'b1;
      tick(2);
      t0 = far.toggles;
      tick(32);
      check(far.toggles - t0, 4);
      $display("enable done");
      wr(OFF_MODE_CONTROL, 32'h0);
      tick(2);
      check(pin_o, 32'h0);
      rdc(OFF_TIMER, 32'h0);
      $display("pwm done");
      summarize();
   end
endmodule
